// File: common/nsx_pkg.sv
// package of constants for the nibble-swap / xor / direction-load datapath
// Notes on behaviour
// - nibble exchange puts source low nibble high and high nibble low
// - nibble exchange: destination 0 writes working register, 1 writes file register
// - literal xor: working register xor 8-bit literal, result to working register
// - file xor: working xor file register, destination 0 to working, 1 to file
// - direction load copies working register to direction register chosen by operand 5 or 6; operand 7 loads none
// - operand 5 loads port A direction, operand 6 loads port B direction
package nsx_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam int unsigned OPSEL_W    = 2;
  localparam logic [1:0]  OP_NONE    = 2'h0;
  localparam logic [1:0]  OP_SWAP    = 2'h1;
  localparam logic [1:0]  OP_XORL    = 2'h2;
  localparam logic [1:0]  OP_XORF    = 2'h3;
  localparam logic [6:0]  DIR_SEL_A  = 7'h05;
  localparam logic [6:0]  DIR_SEL_B  = 7'h06;
  localparam logic [6:0]  DIR_SEL_C  = 7'h07;
  localparam logic [7:0]  WREG_RST   = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'hFF;
  localparam logic        ZERO_RST   = 1'b0;
  localparam logic [6:0]  WADDR_RST  = 7'h00;
  localparam logic [7:0]  WDATA_RST  = 8'h00;
  localparam logic        DEST_WORK  = 1'b0;

  function automatic logic [7:0] nsx_nibble_swap(input logic [7:0] v);
    nsx_nibble_swap = {v[3:0], v[7:4]};
  endfunction : nsx_nibble_swap
endpackage : nsx_pkg

// File: verilog/nsx_alu.sv
// combinational result unit of the datapath
`timescale 1ns/1ps
`default_nettype none
module nsx_alu
  import nsx_pkg::*;
(
  input  wire logic [1:0] op_sel,
  input  wire logic [7:0] work_val,
  input  wire logic [7:0] file_val,
  input  wire logic [7:0] literal_val,
  output logic      [7:0] result,
  output logic            result_zero
);
  wire logic [7:0] swap_res;
  wire logic [7:0] xorl_res;
  wire logic [7:0] xorf_res;
  assign swap_res = nsx_nibble_swap(file_val);
  assign xorl_res = work_val ^ literal_val;
  assign xorf_res = work_val ^ file_val;
  assign result = (op_sel == OP_SWAP) ? swap_res :
                  (op_sel == OP_XORL) ? xorl_res :
                  (op_sel == OP_XORF) ? xorf_res : 8'h00;
  assign result_zero = (result == 8'h00);
endmodule : nsx_alu
`default_nettype wire

// File: verilog/nsx_datapath.sv
// datapath top: working register, zero flag, direction registers, file writeback
`timescale 1ns/1ps
`default_nettype none
module nsx_datapath
  import nsx_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       nibble_exchange_op,
  input  wire logic       xor_literal_op,
  input  wire logic       xor_file_op,
  input  wire logic       direction_load_op,
  input  wire logic       dest_bit,
  input  wire logic [6:0] file_addr,
  input  wire logic [7:0] literal_val,
  input  wire logic [7:0] file_rdata,
  output logic      [7:0] work_q,
  output logic            zero_q,
  output logic      [7:0] port_a_direction,
  output logic      [7:0] port_b_direction,
  output logic            file_we_q,
  output logic      [6:0] file_waddr_q,
  output logic      [7:0] file_wdata_q
);
  logic [7:0] work_d;
  logic       zero_d;
  logic [7:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic       file_we_d;
  wire  logic [1:0] op_sel;
  wire  logic [7:0] alu_res;
  wire  logic       alu_zero;
  wire  logic       to_work;
  wire  logic       to_file;
  wire  logic       xor_any;
  wire  logic       load_a;
  wire  logic       load_b;

  // one operation per cycle; decoder keeps strobes exclusive
  assign op_sel = nibble_exchange_op ? OP_SWAP :
                  xor_literal_op     ? OP_XORL :
                  xor_file_op        ? OP_XORF : OP_NONE;

  nsx_alu u_alu (
    .op_sel      (op_sel),
    .work_val    (work_q),
    .file_val    (file_rdata),
    .literal_val (literal_val),
    .result      (alu_res),
    .result_zero (alu_zero)
  );

  assign to_work = xor_literal_op |
                   ((nibble_exchange_op | xor_file_op) & (dest_bit == DEST_WORK));
  assign to_file = (nibble_exchange_op | xor_file_op) & (dest_bit != DEST_WORK);
  assign xor_any = xor_literal_op | xor_file_op;
  assign load_a  = direction_load_op & (file_addr == DIR_SEL_A);
  assign load_b  = direction_load_op & (file_addr == DIR_SEL_B);

  assign work_d    = to_work ? alu_res : work_q;
  assign zero_d    = xor_any ? alu_zero : zero_q;
  assign file_we_d = to_file;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      work_q <= WREG_RST;
      zero_q <= ZERO_RST;
    end else begin
      work_q <= work_d;
      zero_q <= zero_d;
    end
  end

  // direction load from working register; operand 7 has no port here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_a_q <= DIR_RST;
      dir_b_q <= DIR_RST;
    end else begin
      if (load_a) begin
        dir_a_q <= work_q;
      end
      if (load_b) begin
        dir_b_q <= work_q;
      end
    end
  end
  assign port_a_direction = dir_a_q;
  assign port_b_direction = dir_b_q;

  // writeback is registered, so file sees it one cycle after the op
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_we_q    <= 1'b0;
      file_waddr_q <= WADDR_RST;
      file_wdata_q <= WDATA_RST;
    end else begin
      file_we_q    <= file_we_d;
      file_waddr_q <= file_addr;
      file_wdata_q <= alu_res;
    end
  end

  AST_SWAP_FILE: assert property (@(posedge core_clk) disable iff (!rst_b)
    nibble_exchange_op && dest_bit
    |=> file_we_q
        && file_wdata_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble exchange writeback wrong");

  // exchange goes to the source address
  AST_SWAP_ADDR: assert property (@(posedge core_clk) disable iff (!rst_b)
    nibble_exchange_op && dest_bit
    |=> file_waddr_q == $past(file_addr) && $stable(work_q))
    else $error("nibble exchange address wrong");

  AST_SWAP_WORK: assert property (@(posedge core_clk) disable iff (!rst_b)
    nibble_exchange_op && !dest_bit
    |=> !file_we_q
        && work_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble exchange to working wrong");

  AST_IDLE_NO_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(nibble_exchange_op || xor_file_op)
    |=> !file_we_q)
    else $error("file write without op");

  AST_XORL: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_literal_op
    |=> work_q == ($past(work_q) ^ $past(literal_val)) && !file_we_q)
    else $error("literal xor wrong");

  AST_XORF_FILE: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_file_op && dest_bit
    |=> file_we_q
        && file_wdata_q == ($past(work_q) ^ $past(file_rdata))
        && $stable(work_q))
    else $error("file xor writeback wrong");

  AST_XORF_ADDR: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_file_op && dest_bit
    |=> file_waddr_q == $past(file_addr))
    else $error("file xor address wrong");

  AST_XORF_WORK: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_file_op && !dest_bit
    |=> work_q == ($past(work_q) ^ $past(file_rdata)) && !file_we_q)
    else $error("file xor to working wrong");

  AST_DIR_A: assert property (@(posedge core_clk) disable iff (!rst_b)
    direction_load_op && file_addr == DIR_SEL_A
    |=> port_a_direction == $past(work_q) && $stable(port_b_direction))
    else $error("port A direction load wrong");

  AST_DIR_B: assert property (@(posedge core_clk) disable iff (!rst_b)
    direction_load_op && file_addr == DIR_SEL_B
    |=> port_b_direction == $past(work_q) && $stable(port_a_direction))
    else $error("port B direction load wrong");

  AST_DIR_NONE: assert property (@(posedge core_clk) disable iff (!rst_b)
    direction_load_op && file_addr != DIR_SEL_A && file_addr != DIR_SEL_B
    |=> $stable(port_a_direction) && $stable(port_b_direction))
    else $error("direction changed on unused operand");

  AST_DIR_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
    !direction_load_op
    |=> $stable(port_a_direction) && $stable(port_b_direction))
    else $error("direction changed without load");

  AST_DIR_WORK: assert property (@(posedge core_clk) disable iff (!rst_b)
    direction_load_op
    |=> $stable(work_q) && !file_we_q)
    else $error("direction load disturbed working or file");

  AST_ZERO_XORL: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_literal_op
    |=> zero_q == (($past(work_q) ^ $past(literal_val)) == 8'h00))
    else $error("zero flag wrong after literal xor");

  AST_ZERO_XORF: assert property (@(posedge core_clk) disable iff (!rst_b)
    xor_file_op
    |=> zero_q == (($past(work_q) ^ $past(file_rdata)) == 8'h00))
    else $error("zero flag wrong after file xor");

  AST_ZERO_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(xor_literal_op || xor_file_op)
    |=> $stable(zero_q))
    else $error("zero flag moved without xor");

  COV_SWAP_FILE: cover property (@(posedge core_clk) disable iff (!rst_b)
    nibble_exchange_op && dest_bit);
  COV_XORL_ZERO: cover property (@(posedge core_clk) disable iff (!rst_b)
    xor_literal_op ##1 zero_q);
  COV_XORF_WORK: cover property (@(posedge core_clk) disable iff (!rst_b)
    xor_file_op && !dest_bit);
  COV_DIR_B:     cover property (@(posedge core_clk) disable iff (!rst_b)
    load_b);
  // unused operand still reaches the decoder
  COV_DIR_NONE:  cover property (@(posedge core_clk) disable iff (!rst_b)
    direction_load_op && !load_a && !load_b);
endmodule : nsx_datapath
`default_nettype wire

// File: test/nsx_file_model.sv
// register file model standing behind the datapath's read and writeback ports
`timescale 1ns/1ps
`default_nettype none
module nsx_file_model (
  input  wire logic       core_clk,
  input  wire logic [6:0] file_addr,
  input  wire logic       file_we_q,
  input  wire logic [6:0] file_waddr_q,
  input  wire logic [7:0] file_wdata_q,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [128];
  always @(posedge core_clk) if (file_we_q) mem[file_waddr_q] <= file_wdata_q;
  // read is same-cycle, as the datapath expects
  assign file_rdata = mem[file_addr];
endmodule : nsx_file_model
`default_nettype wire

// File: test/nsx_datapath_tb.sv
// self-checking bench for the datapath
`timescale 1ns/1ps
`default_nettype none
module nsx_datapath_tb;
  logic core_clk = 0, rst_b = 0, sw = 0, xl = 0, xf = 0, dl = 0, d = 0;
  logic [6:0] a = 0, waddr;
  logic [7:0] k = 0, rd, w, z8, pa, pb, wd;
  logic zq, we;
  int failures = 0, n_compared = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  nsx_datapath uut (.core_clk(core_clk), .rst_b(rst_b), .nibble_exchange_op(sw),
    .xor_literal_op(xl), .xor_file_op(xf), .direction_load_op(dl), .dest_bit(d),
    .file_addr(a), .literal_val(k), .file_rdata(rd), .work_q(w), .zero_q(zq),
    .port_a_direction(pa), .port_b_direction(pb), .file_we_q(we),
    .file_waddr_q(waddr), .file_wdata_q(wd));
  nsx_file_model fm (.core_clk(core_clk), .file_addr(a), .file_we_q(we),
    .file_waddr_q(waddr), .file_wdata_q(wd), .file_rdata(rd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one strobe for one cycle; outputs read just after the taking edge
  task automatic run(input logic [3:0] s, input logic dd, input logic [6:0] aa,
                     input logic [7:0] kk);
    @(posedge core_clk) #1 {sw, xl, xf, dl} = s;
    d = dd; a = aa; k = kk;
    @(posedge core_clk) #1 {sw, xl, xf, dl} = 4'h0;
  endtask : run
  task automatic t_xor_lit;
    run(4'h4, 0, 0, 8'hA5); chk("work", 8'hA5, w); chk("zero", 0, zq);
    run(4'h4, 0, 0, 8'hA5); chk("work", 8'h00, w); chk("zero", 1, zq);
    $display("xor literal done");
  endtask : t_xor_lit
  task automatic t_swap;
    fm.mem[16] = 8'h3C; fm.mem[17] = 8'h0F;
    run(4'h8, 0, 16, 0); chk("work", 8'hC3, w); chk("zero", 1, zq);
    run(4'h8, 1, 16, 0); chk("we", 1, we); chk("wdata", 8'hC3, wd);
    chk("waddr", 16, waddr); chk("work", 8'hC3, w);
    $display("nibble exchange done");
  endtask : t_swap
  task automatic t_xor_file;
    run(4'h2, 0, 16, 0); chk("work", 8'h00, w); chk("zero", 1, zq);
    run(4'h2, 1, 17, 0); chk("wdata", 8'h0F, wd); chk("we", 1, we);
    chk("work", 8'h00, w); chk("zero", 0, zq);
    @(posedge core_clk) #1 chk("we", 0, we);
    $display("xor file done");
  endtask : t_xor_file
  task automatic t_dir;
    run(4'h4, 0, 0, 8'h5A);
    run(4'h1, 0, 5, 0); chk("dir a", 8'h5A, pa); chk("dir b", 8'hFF, pb);
    run(4'h1, 0, 6, 0); chk("dir b", 8'h5A, pb); chk("zero", 0, zq);
    run(4'h4, 0, 0, 8'hFF); run(4'h1, 0, 7, 0);
    chk("dir a", 8'h5A, pa); chk("dir b", 8'h5A, pb); chk("we", 0, we);
    $display("direction load done");
  endtask : t_dir
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // hang guard well above the ~43 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 400) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1;
    chk("work", 8'h00, w); chk("dir a", 8'hFF, pa); chk("dir b", 8'hFF, pb);
    chk("zero", 0, zq); chk("we", 0, we);
    $display("reset done");
    t_xor_lit();
    t_swap();
    t_xor_file();
    t_dir();
    complete_run();
  end
endmodule : nsx_datapath_tb
`default_nettype wire
